/* File: core/bridge_type1_config_header.sv */
`timescale 1ns/1ps

// Notes on behaviour
// R1: class code reads 0x060400, read only
// R2: header type reads 0x01, read only
// R3: cache line size is scratch, resets zero
// R4: both latency timers read zero always
// R5: self test byte reads zero always
// R6: both base address registers read zero
// R7: upstream bus number scratch, resets zero
// R8: downstream bus number read write, resets zero
// R9: highest bus number read write, resets zero
// R10: base bit 0 selects io width, resets 1
// R11: limit bit 0 mirrors the capability bit
// R12: base bits 7:4 hold address 15:12, reset f
// R13: limit bits 7:4 hold address 15:12, reset 0
// R14: base and limit steer io forwarding
// R15: forward when base <= addr <= limit
module bridge_type1_config_header
    import bridge_cfg_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // apb slave
    input wire apb_req_t apb_in,
    output apb_rsp_t apb_out,
    // io forwarding decision
    input wire io_req_t io_req_in,
    output io_dec_t io_dec_out,
    // configuration seen by forwarding logic
    output cfg_view_t cfg_out
);

    // stored fields
    logic [7:0] cache_line_r;
    logic [7:0] up_bus_r;
    logic [7:0] down_bus_r;
    logic [7:0] high_bus_r;
    logic io_cap_r;
    logic [3:0] io_base_r;
    logic [3:0] io_limit_r;

    // bus answer registers
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic hit_nxt;

    // decision registers
    logic dec_valid_r;
    logic dec_fwd_r;
    logic fwd_nxt;

    // decode helpers
    logic [11:0] idx;
    logic aligned;
    logic wr_now;
    logic lane0;
    logic [7:0] wbyte;
    logic [7:0] io_low_byte;
    logic [7:0] io_high_byte;

    // one-hot map hit, one bit for each mapped word
    localparam int MAP_ENTRIES = 13;
    localparam logic [11:0] MAP_IDX [MAP_ENTRIES] = '{
        IDX_CLASS_CODE,
        IDX_CACHE_LINE,
        IDX_PRI_LAT,
        IDX_HEADER,
        IDX_SELF_TEST,
        IDX_BASE_ZERO,
        IDX_BASE_ONE,
        IDX_UP_BUS,
        IDX_DOWN_BUS,
        IDX_HIGH_BUS,
        IDX_DOWN_LAT,
        IDX_IO_LOW,
        IDX_IO_HIGH
    };
    logic [MAP_ENTRIES-1:0] reg_hit;

    // per-register write strobes, one for each writable byte
    logic wr_cache;
    logic wr_up;
    logic wr_down;
    logic wr_high;
    logic wr_low_io;
    logic wr_high_io;

    // first access cycle: the answer is prepared here
    logic acc_first;

    // window compare terms
    logic [15:0] io_addr_lo;
    logic [15:0] win_floor;
    logic [15:0] win_ceiling;
    logic above_floor;
    logic below_ceiling;
    logic upper_clear;
    logic win_empty;

    // word index; only aligned word accesses land on a register
    assign idx = apb_in.paddr[ADDR_W-1:2];
    assign aligned = (apb_in.paddr[1:0] == 2'b00);
    assign lane0 = apb_in.pstrb[0];
    assign wbyte = apb_in.pwdata[7:0];

    // the slave answers one cycle into the access phase; pready_r high
    // keeps the second access cycle from being taken as a new request
    assign acc_first = apb_in.psel & apb_in.penable & ~pready_r;

    // a write commits at the edge where the master sees pready high
    assign wr_now = apb_in.psel & apb_in.penable & pready_r & apb_in.pwrite;

    // strobes per field; lane 0 alone carries every writable byte, so a
    // write with that lane off changes nothing and still completes
    assign wr_cache = wr_now & aligned & lane0 & (idx == IDX_CACHE_LINE);
    assign wr_up = wr_now & aligned & lane0 & (idx == IDX_UP_BUS);
    assign wr_down = wr_now & aligned & lane0 & (idx == IDX_DOWN_BUS);
    assign wr_high = wr_now & aligned & lane0 & (idx == IDX_HIGH_BUS);
    assign wr_low_io = wr_now & aligned & lane0 & (idx == IDX_IO_LOW);
    assign wr_high_io = wr_now & aligned & lane0 & (idx == IDX_IO_HIGH);

    // map hit per entry; an index outside the table raises the error
    // answer instead of silently reading zero
    for (genvar g = 0; g < MAP_ENTRIES; g++) begin : g_map_hit
        assign reg_hit[g] = (idx == MAP_IDX[g]);
    end

    // low window byte as software reads it; bits 3:1 are reserved
    // and read zero
    always_comb begin
        io_low_byte = ZERO_BYTE;
        io_low_byte[IO_ADDR_MSB:IO_ADDR_LSB] = io_base_r; // R12
        io_low_byte[IO_CAP_BIT] = io_cap_r; // R10
    end

    // high window byte; bit 0 has no flop of its own, so it can never
    // disagree with the capability bit held in the low byte
    always_comb begin
        io_high_byte = ZERO_BYTE;
        io_high_byte[IO_ADDR_MSB:IO_ADDR_LSB] = io_limit_r; // R13
        io_high_byte[IO_CAP_BIT] = io_cap_r; // R11
    end

    // read mux over the mapped words; upper bytes of byte-wide
    // registers read zero, and unaligned words never hit
    always_comb begin
        rdata_nxt = ZERO_WORD;
        hit_nxt = aligned & (|reg_hit);
        case (idx)
            IDX_CLASS_CODE: begin
                rdata_nxt = {ZERO_BYTE, BASECLASS_VAL, SUBCLASS_VAL, PROG_IF_VAL}; // R1
            end
            IDX_CACHE_LINE: begin
                rdata_nxt = {24'h00_0000, cache_line_r}; // R3
            end
            IDX_PRI_LAT: begin
                rdata_nxt = {24'h00_0000, ZERO_BYTE}; // R4
            end
            IDX_HEADER: begin
                rdata_nxt = {24'h00_0000, HEADER_TYPE_VAL}; // R2
            end
            IDX_SELF_TEST: begin
                rdata_nxt = {24'h00_0000, ZERO_BYTE}; // R5
            end
            IDX_BASE_ZERO: begin
                rdata_nxt = ZERO_WORD; // R6
            end
            IDX_BASE_ONE: begin
                rdata_nxt = ZERO_WORD; // R6
            end
            IDX_UP_BUS: begin
                rdata_nxt = {24'h00_0000, up_bus_r}; // R7
            end
            IDX_DOWN_BUS: begin
                rdata_nxt = {24'h00_0000, down_bus_r}; // R8
            end
            IDX_HIGH_BUS: begin
                rdata_nxt = {24'h00_0000, high_bus_r}; // R9
            end
            IDX_DOWN_LAT: begin
                rdata_nxt = {24'h00_0000, ZERO_BYTE}; // R4
            end
            IDX_IO_LOW: begin
                rdata_nxt = {24'h00_0000, io_low_byte}; // R10
            end
            IDX_IO_HIGH: begin
                rdata_nxt = {24'h00_0000, io_high_byte}; // R11
            end
            default: begin
                rdata_nxt = ZERO_WORD;
            end
        endcase
    end

    // one wait state: pready rises in the second access cycle, so every
    // output stays a flop at the cost of one cycle per transfer
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= acc_first;
        end
    end

    // read data is captured as pready rises and is zero otherwise, so a
    // stale word never shows outside its one answer cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_r <= ZERO_WORD;
        end else if (acc_first) begin
            prdata_r <= apb_in.pwrite ? ZERO_WORD : rdata_nxt;
        end else begin
            prdata_r <= ZERO_WORD;
        end
    end

    // error flags an unmapped or unaligned word; writes there are
    // dropped by the strobes, which need an aligned hit as well
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pslverr_r <= 1'b0;
        end else if (acc_first) begin
            pslverr_r <= ~hit_nxt;
        end else begin
            pslverr_r <= 1'b0;
        end
    end

    // cache line size: stored only, feeds nothing
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cache_line_r <= CACHE_LINE_RST;
        end else if (wr_cache) begin
            cache_line_r <= wbyte; // R3
        end
    end

    // upstream bus number: exported for software, forwarding ignores it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up_bus_r <= BUS_NUM_RST;
        end else if (wr_up) begin
            up_bus_r <= wbyte; // R7
        end
    end

    // downstream bus number of the segment right behind the bridge
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            down_bus_r <= BUS_NUM_RST;
        end else if (wr_down) begin
            down_bus_r <= wbyte; // R8
        end
    end

    // highest bus number behind the bridge; no ordering against the
    // downstream number is enforced, software keeps them consistent
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            high_bus_r <= BUS_NUM_RST;
        end else if (wr_high) begin
            high_bus_r <= wbyte; // R9
        end
    end

    // capability bit; a write switches the width at once, so software
    // should set it before it opens a window
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            io_cap_r <= IO_CAP_RST;
        end else if (wr_low_io) begin
            io_cap_r <= wbyte[IO_CAP_BIT]; // R10
        end
    end

    // base address nibble; reset high so the window starts out empty
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            io_base_r <= IO_BASE_RST;
        end else if (wr_low_io) begin
            io_base_r <= wbyte[IO_ADDR_MSB:IO_ADDR_LSB]; // R12
        end
    end

    // limit address nibble; bit 0 of this byte is not stored
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            io_limit_r <= IO_LIMIT_RST;
        end else if (wr_high_io) begin
            io_limit_r <= wbyte[IO_ADDR_MSB:IO_ADDR_LSB]; // R13
        end
    end

    // window terms on the low sixteen address bits; base pads with
    // zeros and limit with ones, so both ends are inclusive
    assign io_addr_lo = io_req_in.addr[15:0];
    assign win_floor = {io_base_r, IO_LOW_FILL};
    assign win_ceiling = {io_limit_r, IO_HIGH_FILL};
    assign above_floor = (io_addr_lo >= win_floor); // R15
    assign below_ceiling = (io_addr_lo <= win_ceiling); // R15

    // narrow mode cannot reach above 64k; wide mode has no upper window
    // registers in this block, so the upper half is not compared there
    assign upper_clear = (io_width_t'(io_cap_r) == wide_io_addressing) ||
        (io_req_in.addr[31:16] == 16'h0000); // R10

    // base above limit leaves no address that passes both compares;
    // kept as its own term so the empty case is plain to see
    assign win_empty = (io_base_r > io_limit_r); // R15

    // forward only when every term agrees
    always_comb begin
        fwd_nxt = 1'b0;
        if (above_floor && below_ceiling && upper_clear && !win_empty) begin
            fwd_nxt = 1'b1; // R15
        end
    end

    // decision valid one cycle after the request, one per request
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dec_valid_r <= 1'b0;
        end else begin
            dec_valid_r <= io_req_in.valid; // R14
        end
    end

    // forward flag uses the window as it stood at the request edge,
    // so a window write in the same cycle takes effect one cycle later
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dec_fwd_r <= 1'b0;
        end else begin
            dec_fwd_r <= io_req_in.valid & fwd_nxt; // R14
        end
    end

    // bus answer straight from flops
    assign apb_out.pready = pready_r;
    assign apb_out.pslverr = pslverr_r;
    assign apb_out.prdata = prdata_r;

    // forwarding decision straight from flops
    assign io_dec_out.valid = dec_valid_r;
    assign io_dec_out.forward = dec_fwd_r;

    // configuration view straight from flops
    assign cfg_out.up_bus = up_bus_r;
    assign cfg_out.down_bus = down_bus_r;
    assign cfg_out.high_bus = high_bus_r;
    assign cfg_out.io_cap = io_cap_r;
    assign cfg_out.io_base = io_base_r;
    assign cfg_out.io_limit = io_limit_r;

endmodule // bridge_type1_config_header

/* File: inc/bridge_cfg_pkg.sv */
package bridge_cfg_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [11:0] IDX_CLASS_CODE = 12'h009;
    localparam logic [11:0] IDX_CACHE_LINE = 12'h00c;
    localparam logic [11:0] IDX_PRI_LAT = 12'h00d;
    localparam logic [11:0] IDX_HEADER = 12'h00e;
    localparam logic [11:0] IDX_SELF_TEST = 12'h00f;
    localparam logic [11:0] IDX_BASE_ZERO = 12'h010;
    localparam logic [11:0] IDX_BASE_ONE = 12'h014;
    localparam logic [11:0] IDX_UP_BUS = 12'h018;
    localparam logic [11:0] IDX_DOWN_BUS = 12'h019;
    localparam logic [11:0] IDX_HIGH_BUS = 12'h01a;
    localparam logic [11:0] IDX_DOWN_LAT = 12'h01b;
    localparam logic [11:0] IDX_IO_LOW = 12'h01c;
    localparam logic [11:0] IDX_IO_HIGH = 12'h01d;
    localparam int ADDR_W = 14;

    // fixed identification values
    localparam logic [7:0] PROG_IF_VAL = 8'h00;
    localparam logic [7:0] SUBCLASS_VAL = 8'h04;
    localparam logic [7:0] BASECLASS_VAL = 8'h06;
    localparam logic [7:0] HEADER_TYPE_VAL = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // reset values of the writable fields
    localparam logic [7:0] CACHE_LINE_RST = 8'h00;
    localparam logic [7:0] BUS_NUM_RST = 8'h00;
    localparam logic [3:0] IO_BASE_RST = 4'hf;
    localparam logic [3:0] IO_LIMIT_RST = 4'h0;
    localparam logic IO_CAP_RST = 1'b1;

    // field positions inside the io window bytes
    localparam int IO_CAP_BIT = 0;
    localparam int IO_ADDR_LSB = 4;
    localparam int IO_ADDR_MSB = 7;
    localparam logic [11:0] IO_LOW_FILL = 12'h000;
    localparam logic [11:0] IO_HIGH_FILL = 12'hfff;

    // width modes of the io capability bit
    typedef enum logic {
        narrow_io_addressing = 1'b0,
        wide_io_addressing = 1'b1
    } io_width_t;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_t;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // io request offered for a forwarding decision
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } io_req_t;

    // forwarding decision for that request
    typedef struct packed {
        logic valid;
        logic forward;
    } io_dec_t;

    // bus numbers and window seen by other blocks
    typedef struct packed {
        logic [7:0] up_bus;
        logic [7:0] down_bus;
        logic [7:0] high_bus;
        logic io_cap;
        logic [3:0] io_base;
        logic [3:0] io_limit;
    } cfg_view_t;

endpackage

/* File: test/bridge_hdr_assertions.sv */
`timescale 1ns/1ps
module bridge_hdr_checker
    import bridge_cfg_pkg::*;
(
    // watched ports
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire apb_req_t apb_in,
    input wire apb_rsp_t apb_out,
    input wire io_req_t io_req_in,
    input wire io_dec_t io_dec_out,
    input wire cfg_view_t cfg_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic rd_done;
    logic exp_fwd;
    // a read completing at this edge
    assign rd_done = apb_in.psel && apb_in.penable && !apb_in.pwrite && apb_out.pready;
    // empty window falls out of the two compares, no separate test needed
    assign exp_fwd = io_req_in.addr[15:0] >= {cfg_out.io_base, 12'h000}
        && io_req_in.addr[15:0] <= {cfg_out.io_limit, 12'hfff}
        && (cfg_out.io_cap || io_req_in.addr[31:16] == 16'h0000);
    a_class_fixed: assert property (rd_done && apb_in.paddr == 14'h024
        |-> apb_out.prdata == 32'h0006_0400) else $error("class code wrong");
    a_header_fixed: assert property (rd_done && apb_in.paddr == 14'h038
        |-> apb_out.prdata == 32'h0000_0001) else $error("header type wrong");
    a_bar_zero: assert property (rd_done && (apb_in.paddr == 14'h040
        || apb_in.paddr == 14'h050) |-> apb_out.prdata == 32'h0) else $error("bar not zero");
    a_mirror_cap: assert property (rd_done && apb_in.paddr == 14'h074
        |-> apb_out.prdata[3:0] == {3'b000, cfg_out.io_cap}) else $error("cap mirror wrong");
    a_reset_view: assert property ($rose(rst_n_in)
        |-> cfg_out == {24'h0, 1'b1, 4'hf, 4'h0}) else $error("reset view wrong");
    a_dec_timing: assert property (io_req_in.valid |=> io_dec_out.valid)
        else $error("decision missing");
    a_dec_cause: assert property (io_dec_out.valid |-> $past(io_req_in.valid))
        else $error("decision without request");
    a_fwd_rule: assert property (io_req_in.valid
        |=> io_dec_out.forward == $past(exp_fwd)) else $error("forward wrong");
    a_empty_win: assert property (io_req_in.valid && cfg_out.io_base > cfg_out.io_limit
        |=> !io_dec_out.forward) else $error("empty window forwarded");
    a_narrow_upper: assert property (io_req_in.valid && !cfg_out.io_cap
        && |io_req_in.addr[31:16] |=> !io_dec_out.forward) else $error("narrow upper forwarded");
    c_forward: cover property (io_dec_out.valid && io_dec_out.forward);
    c_error: cover property (apb_out.pready && apb_out.pslverr);
    c_narrow: cover property (io_req_in.valid && !cfg_out.io_cap);
endmodule // bridge_hdr_checker

bind bridge_type1_config_header bridge_hdr_checker u_chk (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .apb_in(apb_in), .apb_out(apb_out), .io_req_in(io_req_in),
    .io_dec_out(io_dec_out), .cfg_out(cfg_out));

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top import bridge_cfg_pkg::*;;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    apb_req_t apb_in = '0;
    apb_rsp_t apb_out;
    io_req_t io_req_in = '0;
    io_dec_t io_dec_out;
    cfg_view_t cfg_out;
    int miscompares = 0;
    int compares = 0;
    logic [13:0] map_addr [13] = '{14'h024, 14'h030, 14'h034, 14'h038, 14'h03c, 14'h040,
        14'h050, 14'h060, 14'h064, 14'h068, 14'h06c, 14'h070, 14'h074};
    logic [13:0] bad_addr [3] = '{14'h02c, 14'h062, 14'h3fc};
    logic [31:0] val [13];
    logic [31:0] rw_m [13];
    logic [31:0] rd;
    logic [31:0] d;
    logic er;

    bridge_type1_config_header dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .apb_in(apb_in),
        .apb_out(apb_out), .io_req_in(io_req_in), .io_dec_out(io_dec_out), .cfg_out(cfg_out));

    // 250 MHz clock
    initial begin
        forever #2 clk_in = ~clk_in;
    end

    task check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one apb transfer; request held until the edge that samples pready high
    task apb(input logic w, input logic [13:0] a, input logic [31:0] wd);
        @(posedge clk_in);
        apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd, pstrb: 4'hf};
        @(posedge clk_in);
        apb_in.penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (apb_out.pready !== 1'b1);
        rd = apb_out.prdata;
        er = apb_out.pslverr;
        apb_in.psel <= 1'b0;
        apb_in.penable <= 1'b0;
    endtask

    // io limit bit 0 always follows the capability bit of the base byte
    function automatic logic [31:0] expv(int i);
        if (i == 12)
            return (val[12] & 32'hf0) | (val[11] & 32'h1);
        return val[i];
    endfunction

    function automatic logic fwd(logic [31:0] a);
        return a[15:0] >= {val[11][7:4], 12'h000} && a[15:0] <= {val[12][7:4], 12'hfff}
            && (val[11][0] || a[31:16] == 16'h0000);
    endfunction

    task sweep;
        for (int i = 0; i < 13; i++) begin
            apb(1'b0, map_addr[i], 32'h0);
            check(rd, expv(i));
            check(er, 1'b0);
        end
        check({cfg_out.up_bus, cfg_out.down_bus, cfg_out.high_bus},
            {val[7][7:0], val[8][7:0], val[9][7:0]});
        check({cfg_out.io_cap, cfg_out.io_base, cfg_out.io_limit},
            {val[11][0], val[11][7:4], val[12][7:4]});
    endtask

    task io_try(input logic [31:0] a);
        @(posedge clk_in);
        io_req_in <= '{valid: 1'b1, addr: a};
        @(posedge clk_in);
        io_req_in.valid <= 1'b0;
        @(negedge clk_in);
        check(io_dec_out.valid, 1'b1);
        check(io_dec_out.forward, fwd(a));
    endtask

    // main sequence: reset values, refused accesses, then random write rounds
    initial begin
        void'($urandom(69));
        val = '{default: 32'h0};
        rw_m = '{default: 32'h0};
        val[0] = 32'h0006_0400;
        val[3] = 32'h1;
        val[11] = 32'hf1;
        rw_m[1] = 32'hff;
        rw_m[7] = 32'hff;
        rw_m[8] = 32'hff;
        rw_m[9] = 32'hff;
        rw_m[11] = 32'hf1;
        rw_m[12] = 32'hf0;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        sweep();
        foreach (bad_addr[k]) begin
            apb(1'b1, bad_addr[k], 32'hffff_ffff);
            check(er, 1'b1);
            apb(1'b0, bad_addr[k], 32'h0);
            check(er, 1'b1);
            check(rd, 32'h0);
        end
        for (int r = 0; r < 8; r++) begin
            // first round is a hand-picked narrow window 0x2000..0x5fff
            for (int i = 0; i < 13; i++) begin
                d = (r == 0 && i == 11) ? 32'h20 : (r == 0 && i == 12) ? 32'h51 : $urandom;
                apb(1'b1, map_addr[i], d);
                check(rd, 32'h0);
                val[i] = (val[i] & ~rw_m[i]) | (d & rw_m[i]);
            end
            sweep();
            d = $urandom;
            io_try({d[31:16], val[11][7:4], 12'h000});
            io_try({16'h0, val[11][7:4], 12'h000} - 32'h1);
            io_try({16'h0, val[12][7:4], 12'hfff});
            io_try({16'h0, val[12][7:4], 12'hfff} + 32'h1);
            io_try(d);
        end
        // mid-run reset brings every field back to its reset value
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        foreach (val[i])
            val[i] = val[i] & ~rw_m[i];
        val[11] = 32'hf1;
        sweep();
        wrap_up();
    end

    // hang guard, well beyond the thousand or so cycles the tests take
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
endmodule // tb_top
